/* pmic_id_path_irq_regs.sv */
/*
 * Identity, supply-path control and event register bank with sink
 * control, path enables, current limits and the host interrupt.
 * Assumes a synchronous 8-bit register port from the serial engine
 * and supply detection inputs synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Read-only identity byte at 0x00: part code high, revision low.
// - Part code never takes the reserved values 1001b to 1101b.
// - Mains sink bit 0: mains sink on when USB valid and mains low.
// - USB sink bit 0: USB sink on when mains valid and USB low.
// - Both sink bits 1: both sinks forced off.
// - Bit 5 turns mains input off when 0, on when 1; resets 1.
// - Bit 4 suspends USB input when 0, on when 1; resets 1.
// - Bits 3-2 choose mains limit 100/500/1300/2500 mA; reset 11b.
// - Bits 1-0 choose USB limit 100/500/1300/1800 mA; reset 01b.
// - Button flag sets on a button input level change, except in the cycle after a return to defaults.
// - Mains flag sets when mains power is applied or removed.
// - USB flag sets when USB power is applied or removed.
// - Button mask bit 6 blocks button interrupts; resets 0.
// - Mains mask bit 5 blocks mains interrupts; resets 0.
// - USB mask bit 4 blocks USB interrupts; resets 0.
// - Event bit 7 reserved writable, resets 1; bit 3 reads 0.
// - Flags record transitions; present levels come out separately.
// - Supply path resets to 0x3D, event register to 0x80.
// - Charger state register at 0x03 resets to 0x00.
// - Defaults return on sleep, power-on, long hold, reset pin, fault.
module pmic_id_path_irq_regs
   import pmic_regs_pkg::*;
#(
   parameter logic [3:0] PART_CODE = 4'h4, // Value arbitrary
   parameter logic [3:0] SILICON_VERSION = 4'h3, // Value arbitrary
   parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_rd,
   input wire logic i_button_input,
   input wire logic i_mains_valid,
   input wire logic i_usb_valid,
   input wire logic i_mains_below_thr,
   input wire logic i_usb_below_thr,
   input wire logic [7:0] i_charger_state,
   input wire logic i_hard_reset_pin_n,
   input wire logic i_sleep_entry,
   input wire logic i_fault,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_mains_sink_en,
   output logic o_usb_sink_en,
   output logic o_mains_path_enable,
   output logic o_usb_path_enable,
   output logic [1:0] o_mains_current_limit,
   output logic [1:0] o_usb_current_limit,
   output logic o_button_level,
   output logic o_mains_present,
   output logic o_usb_present,
   output logic o_irq
);
   localparam logic [7:0] IDENTITY = {PART_CODE, SILICON_VERSION};

   initial begin
      if (PART_CODE >= PART_RSVD_LO && PART_CODE <= PART_RSVD_HI) begin
         $error("Part code lies in the reserved range");
      end
      if (HOLD_CYCLES < 1 || HOLD_CYCLES > 32'h3fff_ffff) begin
         $error("Hold count out of range");
      end
   end

   logic [7:0] supply_path_reg;
   logic [3:0] ev_ctrl_reg;
   logic [7:0] charger_state_reg;
   logic [29:0] hold_cnt_reg;
   logic hold_done;
   logic defaults;
   logic ev_read;
   logic [2:0] flags;
   logic [7:0] event_view;
   logic [7:0] rdata_next;
   logic mains_ctrl;
   logic usb_ctrl;

   // Long button hold (input pulled low) counted in cycles
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_cnt_reg <= '0;
      end else if (i_button_input) begin
         hold_cnt_reg <= '0;
      end else if (!hold_done) begin
         hold_cnt_reg <= hold_cnt_reg + 30'h1;
      end
   end
   assign hold_done = hold_cnt_reg == 30'(HOLD_CYCLES);

   // Every source of a return to defaults but power-on acts as a synchronous clear
   assign defaults = !i_hard_reset_pin_n || i_sleep_entry || i_fault ||
      hold_done;

   assign ev_read = i_reg_rd && i_reg_addr == EVENT_FLAGS_OFS;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         supply_path_reg <= SUPPLY_PATH_RST;
      end else if (defaults) begin
         supply_path_reg <= SUPPLY_PATH_RST;
      end else if (i_reg_wr && i_reg_addr == SUPPLY_PATH_OFS) begin
         supply_path_reg <= i_reg_wdata;
      end
   end

   // Upper nibble of the event register: reserved bit and masks
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ev_ctrl_reg <= EVENT_FLAGS_RST[7:4];
      end else if (defaults) begin
         ev_ctrl_reg <= EVENT_FLAGS_RST[7:4];
      end else if (i_reg_wr && i_reg_addr == EVENT_FLAGS_OFS) begin
         ev_ctrl_reg <= i_reg_wdata[7:4] & EV_WRITE_MASK[7:4];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         charger_state_reg <= CHARGER_STATE_RST;
      end else if (defaults) begin
         charger_state_reg <= CHARGER_STATE_RST;
      end else begin
         charger_state_reg <= i_charger_state;
      end
   end

   change_flag_cell u_button_flag (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_defaults(defaults),
      .i_level(i_button_input),
      .i_read_clear(ev_read),
      .o_flag(flags[2]),
      .o_level(o_button_level)
   );
   change_flag_cell u_mains_flag (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_defaults(defaults),
      .i_level(i_mains_valid),
      .i_read_clear(ev_read),
      .o_flag(flags[1]),
      .o_level(o_mains_present)
   );
   change_flag_cell u_usb_flag (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_defaults(defaults),
      .i_level(i_usb_valid),
      .i_read_clear(ev_read),
      .o_flag(flags[0]),
      .o_level(o_usb_present)
   );

   // Bit 3 is hard zero; levels are not mixed into the flags
   assign event_view = {ev_ctrl_reg, 1'b0, flags};

   always_comb begin
      case (i_reg_addr)
         IDENTITY_OFS: rdata_next = IDENTITY;
         SUPPLY_PATH_OFS: rdata_next = supply_path_reg;
         EVENT_FLAGS_OFS: rdata_next = event_view;
         CHARGER_STATE_OFS: rdata_next = charger_state_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_next;
         end
      end
   end

   assign mains_ctrl = supply_path_reg[MAINS_SINK_BIT];
   assign usb_ctrl = supply_path_reg[USB_SINK_BIT];

   // Mixed control patterns leave the sink whose bit is set off; the
   // cheapest safe reading of a combination software must avoid
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mains_sink_en <= 1'b0;
         o_usb_sink_en <= 1'b0;
      end else begin
         o_mains_sink_en <= !mains_ctrl && i_usb_valid && i_mains_below_thr;
         o_usb_sink_en <= !usb_ctrl && i_mains_valid && i_usb_below_thr;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mains_path_enable <= SUPPLY_PATH_RST[MAINS_EN_BIT];
         o_usb_path_enable <= SUPPLY_PATH_RST[USB_EN_BIT];
         o_mains_current_limit <= SUPPLY_PATH_RST[MAINS_LIM_LSB +: 2];
         o_usb_current_limit <= SUPPLY_PATH_RST[USB_LIM_LSB +: 2];
      end else begin
         o_mains_path_enable <= supply_path_reg[MAINS_EN_BIT];
         o_usb_path_enable <= supply_path_reg[USB_EN_BIT];
         o_mains_current_limit <= supply_path_reg[MAINS_LIM_LSB +: 2];
         o_usb_current_limit <= supply_path_reg[USB_LIM_LSB +: 2];
      end
   end

   // Level request, held while any unmasked flag stands
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(flags & ~ev_ctrl_reg[2:0]);
      end
   end

   property p_identity_read;
      @(posedge i_clk) disable iff (!i_resetn)
      i_reg_rd && i_reg_addr == IDENTITY_OFS |=> o_reg_rvalid &&
         o_reg_rdata == IDENTITY;
   endproperty
   a_identity_read: assert property (p_identity_read)
      else $error("Identity read returned wrong byte");

   property p_part_code;
      @(posedge i_clk) disable iff (!i_resetn)
      o_reg_rvalid && $past(i_reg_addr) == IDENTITY_OFS |->
         !(o_reg_rdata[7:4] inside {[PART_RSVD_LO:PART_RSVD_HI]});
   endproperty
   a_part_code: assert property (p_part_code)
      else $error("Reserved part code reported");

   property p_mains_sink;
      @(posedge i_clk) disable iff (!i_resetn)
      !mains_ctrl && i_usb_valid && i_mains_below_thr |=> o_mains_sink_en;
   endproperty
   a_mains_sink: assert property (p_mains_sink)
      else $error("Mains sink not enabled");

   property p_usb_sink;
      @(posedge i_clk) disable iff (!i_resetn)
      !usb_ctrl && i_mains_valid && i_usb_below_thr |=> o_usb_sink_en;
   endproperty
   a_usb_sink: assert property (p_usb_sink)
      else $error("USB sink not enabled");

   property p_sinks_forced_off;
      @(posedge i_clk) disable iff (!i_resetn)
      (mains_ctrl && usb_ctrl) [*2] |-> !o_mains_sink_en && !o_usb_sink_en;
   endproperty
   a_sinks_forced_off: assert property (p_sinks_forced_off)
      else $error("Sink on while both forced off");

   property p_path_write;
      @(posedge i_clk) disable iff (!i_resetn || defaults)
      i_reg_wr && i_reg_addr == SUPPLY_PATH_OFS ##1 !defaults |=>
         o_mains_path_enable == $past(i_reg_wdata[MAINS_EN_BIT], 2) &&
         o_usb_current_limit == $past(i_reg_wdata[1:0], 2);
   endproperty
   a_path_write: assert property (p_path_write)
      else $error("Path outputs do not follow the write");

   property p_defaults;
      @(posedge i_clk) disable iff (!i_resetn)
      defaults |=> supply_path_reg == SUPPLY_PATH_RST &&
         ev_ctrl_reg == EVENT_FLAGS_RST[7:4] && flags == 3'h0;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("Registers not at defaults");

   property p_button_flag;
      @(posedge i_clk) disable iff (!i_resetn)
      $changed(o_button_level) && $past(!defaults) &&
         $past(u_button_flag.primed_reg) |-> flags[2];
   endproperty
   a_button_flag: assert property (p_button_flag)
      else $error("Button change not flagged");

   property p_event_read;
      @(posedge i_clk) disable iff (!i_resetn)
      ev_read |=> o_reg_rdata[EV_RSVD_RO_BIT] == 1'b0 &&
         o_reg_rdata[2:0] == $past(flags);
   endproperty
   a_event_read: assert property (p_event_read)
      else $error("Event read data wrong");

   property p_irq;
      @(posedge i_clk) disable iff (!i_resetn)
      ##1 o_irq == $past(
         (event_view[BUTTON_FLAG_BIT] && !event_view[BUTTON_MASK_BIT]) ||
         (event_view[MAINS_FLAG_BIT] && !event_view[MAINS_MASK_BIT]) ||
         (event_view[USB_FLAG_BIT] && !event_view[USB_MASK_BIT]));
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt does not match unmasked flags");

   c_button_irq: cover property (@(posedge i_clk) disable iff (!i_resetn)
      flags[2] && !ev_ctrl_reg[2] ##1 o_irq);
   c_flag_read: cover property (@(posedge i_clk) disable iff (!i_resetn)
      ev_read && flags[0] ##1 !flags[0]);
   c_mains_sink: cover property (@(posedge i_clk) disable iff (!i_resetn)
      o_mains_sink_en);
   c_long_hold: cover property (@(posedge i_clk) disable iff (!i_resetn)
      hold_done);
endmodule
`default_nettype wire

/* pmic_regs_pkg.sv */
/*
 * Shared constants for the supply-path and event register bank:
 * register offsets, field positions, values after reset and timing.
 * Assumes an 8-bit register port driven by the serial management engine.
 */
package pmic_regs_pkg;
   localparam logic [7:0] IDENTITY_OFS = 8'h00;
   localparam logic [7:0] SUPPLY_PATH_OFS = 8'h01;
   localparam logic [7:0] EVENT_FLAGS_OFS = 8'h02;
   localparam logic [7:0] CHARGER_STATE_OFS = 8'h03;

   localparam logic [7:0] SUPPLY_PATH_RST = 8'h3d;
   localparam logic [7:0] EVENT_FLAGS_RST = 8'h80;
   localparam logic [7:0] CHARGER_STATE_RST = 8'h00;

   // Supply-path fields
   localparam int MAINS_SINK_BIT = 7;
   localparam int USB_SINK_BIT = 6;
   localparam int MAINS_EN_BIT = 5;
   localparam int USB_EN_BIT = 4;
   localparam int MAINS_LIM_LSB = 2;
   localparam int USB_LIM_LSB = 0;

   // Event register fields
   localparam int EV_RSVD_RW_BIT = 7;
   localparam int BUTTON_MASK_BIT = 6;
   localparam int MAINS_MASK_BIT = 5;
   localparam int USB_MASK_BIT = 4;
   localparam int EV_RSVD_RO_BIT = 3;
   localparam int BUTTON_FLAG_BIT = 2;
   localparam int MAINS_FLAG_BIT = 1;
   localparam int USB_FLAG_BIT = 0;
   localparam logic [7:0] EV_WRITE_MASK = 8'hf0;

   // Identity nibble ranges that must never be reported
   localparam logic [3:0] PART_RSVD_LO = 4'h9;
   localparam logic [3:0] PART_RSVD_HI = 4'hd;

   // Long button hold that returns registers to defaults
   localparam int unsigned CLK_FREQ_KHZ = 100_000;
   localparam int unsigned HOLD_TIME_MS = 8000;
   localparam int unsigned HOLD_CYCLES_DEF = HOLD_TIME_MS * CLK_FREQ_KHZ;
endpackage

/* change_flag_cell.sv */
/*
 * One sticky change flag: sets on a level change of its input, except in the cycle after a reset or a return to defaults,
 * clears on a read of the flags or on a return to defaults.
 * Assumes the input is synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module change_flag_cell (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_defaults,
   input wire logic i_level,
   input wire logic i_read_clear,
   output logic o_flag,
   output logic o_level
);
   logic primed_reg;
   logic change;

   // No edge is taken before the first sample after any reset
   assign change = primed_reg && (i_level != o_level);

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         primed_reg <= 1'b0;
         o_level <= 1'b0;
      end else begin
         primed_reg <= !i_defaults;
         o_level <= i_level;
      end
   end

   // Set wins over a read clear so no change is lost
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag <= 1'b0;
      end else if (i_defaults) begin
         o_flag <= 1'b0;
      end else if (change) begin
         o_flag <= 1'b1;
      end else if (i_read_clear) begin
         o_flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* host_bus_model.sv */
/*
 * Host side of the register byte port: single-byte reads and writes.
 * Assumes the bank takes strobes on the rising edge of i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
   import pmic_regs_pkg::*;
(
   input wire logic i_clk,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   output logic [7:0] o_reg_addr,
   output logic o_reg_wr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_rd
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end

   // Strobes move on the falling edge and last one cycle
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_wdata = (a == EVENT_FLAGS_OFS) ? (d | 8'h80) : d;
      o_reg_wr = 1'b1;
      @(negedge i_clk);
      o_reg_wr = 1'b0;
      // Data no longer qualified, so it is scrambled
      o_reg_wdata = ~d;
   endtask

   // Answer is due exactly one cycle after the read edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
         output logic ok);
      @(negedge i_clk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      // Valid stands one cycle only, so take the answer at the next fall
      @(negedge i_clk);
      ok = i_reg_rvalid;
      d = i_reg_rdata;
      o_reg_rd = 1'b0;
   endtask
endmodule
`default_nettype wire

/* pmic_id_path_irq_regs_tb.sv */
/*
 * Self-checking bench for the identity, supply-path and event bank.
 * Assumes a 100 MHz clock and a shortened button hold count.
 */
`timescale 1ns/1ps
`default_nettype none
module pmic_id_path_irq_regs_tb
   import pmic_regs_pkg::*;
;
   localparam int HOLD = 60;
   // Identity values arbitrary
   localparam logic [7:0] ID = 8'h43;
   logic i_clk = 0, i_resetn = 0, i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [7:0] i_charger_state = 8'h00;
   logic i_button_input = 1, i_mains_valid = 0, i_usb_valid = 0;
   logic i_mains_below_thr = 0, i_usb_below_thr = 0;
   logic i_hard_reset_pin_n = 1, i_sleep_entry = 0, i_fault = 0;
   logic o_mains_sink_en, o_usb_sink_en, o_mains_path_enable;
   logic o_usb_path_enable, o_button_level, o_mains_present;
   logic o_usb_present, o_irq;
   logic [1:0] o_mains_current_limit, o_usb_current_limit;
   int num_errors = 0, total_checks = 0;
   wire logic [7:0] path_o = {2'b00, o_mains_path_enable,
      o_usb_path_enable, o_mains_current_limit, o_usb_current_limit};
   wire logic [7:0] sink_o = {6'h0, o_mains_sink_en, o_usb_sink_en};
   wire logic [7:0] lev_o = {5'h0, o_button_level, o_mains_present,
      o_usb_present};
   wire logic [7:0] lev_i = {5'h0, i_button_input, i_mains_valid,
      i_usb_valid};

   always #5 i_clk = ~i_clk;

   pmic_id_path_irq_regs #(.PART_CODE(ID[7:4]),
      .SILICON_VERSION(ID[3:0]), .HOLD_CYCLES(HOLD))
   pmic_id_path_irq_regs_inst (.i_clk, .i_resetn, .i_reg_addr,
      .i_reg_wr, .i_reg_wdata, .i_reg_rd, .i_button_input,
      .i_mains_valid, .i_usb_valid, .i_mains_below_thr,
      .i_usb_below_thr, .i_charger_state, .i_hard_reset_pin_n,
      .i_sleep_entry, .i_fault, .o_reg_rdata, .o_reg_rvalid,
      .o_mains_sink_en, .o_usb_sink_en, .o_mains_path_enable,
      .o_usb_path_enable, .o_mains_current_limit,
      .o_usb_current_limit, .o_button_level, .o_mains_present,
      .o_usb_present, .o_irq);

   host_bus_model host_bus_model_inst (.i_clk,
      .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
      .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
      .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A missing answer ends the run at once
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic ok;
      host_bus_model_inst.read_reg(a, d, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("mismatch rvalid expected 1 seen %b", ok);
         tally_and_finish();
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, e);
      logic [7:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask

   task automatic wr(input logic [7:0] a, d);
      host_bus_model_inst.write_reg(a, d);
   endtask

   // Level outputs reset low while the button idles high: no false flag
   task automatic reset_values();
      chk("path outs", 8'h3d, path_o);
      rdc("identity", IDENTITY_OFS, ID);
      rdc("path", SUPPLY_PATH_OFS, 8'h3d);
      rdc("event", EVENT_FLAGS_OFS, 8'h80);
      rdc("charger", CHARGER_STATE_OFS, 8'h00);
   endtask

   task automatic refusals();
      wr(IDENTITY_OFS, 8'hff);
      rdc("identity wr", IDENTITY_OFS, ID);
      wr(8'h07, 8'h55);
      rdc("unmapped", 8'h07, 8'h00);
      wr(EVENT_FLAGS_OFS, 8'hff);
      rdc("event wr", EVENT_FLAGS_OFS, 8'hf0);
      wr(EVENT_FLAGS_OFS, 8'h80);
      i_charger_state = 8'ha5;
      wr(CHARGER_STATE_OFS, 8'h00);
      rdc("charger", CHARGER_STATE_OFS, 8'ha5);
   endtask

   // Supplies set so that only the forced-off pattern keeps sinks off
   task automatic path_fields();
      logic [7:0] v;
      {i_mains_valid, i_usb_valid} = 2'b11;
      {i_mains_below_thr, i_usb_below_thr} = 2'b11;
      for (int i = 0; i < 4; i++) begin
         v = {2'b11, i[1:0], i[1:0], ~i[1:0]};
         wr(SUPPLY_PATH_OFS, v);
         repeat (2) @(negedge i_clk);
         chk("path outs", {2'b00, v[5:0]}, path_o);
         chk("sinks off", 8'h00, sink_o);
         rdc("path rd", SUPPLY_PATH_OFS, v);
      end
   endtask

   task automatic sink_cases();
      logic [5:0] t [4] = '{6'b011010, 6'b100101, 6'b111111, 6'b110000};
      wr(SUPPLY_PATH_OFS, 8'h3d);
      foreach (t[j]) begin
         {i_mains_valid, i_usb_valid} = t[j][5:4];
         {i_mains_below_thr, i_usb_below_thr} = t[j][3:2];
         repeat (2) @(negedge i_clk);
         chk("sinks", {6'h0, t[j][1:0]}, sink_o);
      end
   endtask

   task automatic flip(input int k);
      @(negedge i_clk);
      case (k)
         0: i_usb_valid = ~i_usb_valid;
         1: i_mains_valid = ~i_mains_valid;
         default: i_button_input = ~i_button_input;
      endcase
      repeat (2) @(negedge i_clk);
   endtask

   task automatic flag_cases();
      logic [7:0] d;
      rd(EVENT_FLAGS_OFS, d);
      for (int k = 0; k < 3; k++) begin
         flip(k);
         chk("irq", 8'h01, {7'h0, o_irq});
         chk("levels", lev_i, lev_o);
         rdc("flag", EVENT_FLAGS_OFS, 8'h80 | (8'h01 << k));
         @(negedge i_clk);
         chk("irq clear", 8'h00, {7'h0, o_irq});
         rdc("flag gone", EVENT_FLAGS_OFS, 8'h80);
         wr(EVENT_FLAGS_OFS, 8'h80 | (8'h10 << k));
         flip(k);
         chk("irq masked", 8'h00, {7'h0, o_irq});
         rdc("flag masked", EVENT_FLAGS_OFS, 8'h80 | (8'h11 << k));
         wr(EVENT_FLAGS_OFS, 8'h80);
      end
   endtask

   // Last source is a second asynchronous reset in mid-run
   task automatic defaults_cases();
      for (int s = 0; s < 5; s++) begin
         wr(SUPPLY_PATH_OFS, 8'h00);
         wr(EVENT_FLAGS_OFS, 8'hf0);
         @(negedge i_clk);
         case (s)
            0: i_hard_reset_pin_n = 0;
            1: i_sleep_entry = 1;
            2: i_fault = 1;
            3: i_button_input = 0;
            default: i_resetn = 0;
         endcase
         repeat (s == 3 ? HOLD + 10 : 1) @(negedge i_clk);
         {i_hard_reset_pin_n, i_sleep_entry, i_fault} = 3'b100;
         i_button_input = 1;
         i_resetn = 1;
         rdc("path default", SUPPLY_PATH_OFS, 8'h3d);
         rdc("event default", EVENT_FLAGS_OFS, 8'h80);
      end
   endtask

   initial begin
      repeat (5) @(negedge i_clk);
      i_resetn = 1;
      reset_values();
      refusals();
      path_fields();
      sink_cases();
      flag_cases();
      defaults_cases();
      tally_and_finish();
   end
endmodule
`default_nettype wire
